// ### pkg/wwdt_cfg.svh
// Purpose: constants for the windowed watchdog timer
// Assumes: 125 MHz system clock, 31 kHz low-power RC tick arrives as a pin level
// Notes: included by the wwdt_top design file only
// Contract
// - Counter runs on RC oscillator; enable starts it
// - Prescaler divides by 32 or 128
// - Base period about 1 or 4 ms
// - Postscaler offers 16 settings, 1:1 to 1:32768
// - Any device reset zeroes whole chain
// - Clock switch completion clears chain
// - Power-save entry clears chain
// - Leaving Sleep or Idle clears chain
// - Clear instruction clears chain, window permitting
// - Hardware-always-on keeps counting in Sleep, Idle
// - Time-out in low power wakes device
// - Time-out flag sticky; software clears it
// - Window mode: clear only in final quarter
// - Early clear in window mode resets device
// - Window disable bit zero selects window mode
// - Enable field 11 runs always
// - Enable field 10 follows software enable
// - Device reset clears software enable
// - Enable field 01 runs except in Sleep
// - Prescale bit one 1:128, zero 1:32
// - Postscale ratio is two to field power
// - Enable field 00 disables, software ignored
// - Disabled watchdog: early clear no reset
`ifndef WWDT_CFG_SVH
`define WWDT_CFG_SVH
`define WWDT_PRE_SMALL 7'h1f
`define WWDT_PRE_LARGE 7'h7f
`define WWDT_POST_W 15
`define WWDT_EN_OFF 2'h0
`define WWDT_EN_ACTIVE 2'h1
`define WWDT_EN_SW 2'h2
`define WWDT_EN_HW 2'h3
`define WWDT_WIN_SHIFT 2
`define WWDT_PULSE_CYC 4'h3
`endif

// ### pkg/wwdt_pkg.sv
// Purpose: types of the windowed watchdog timer
// Assumes: nothing beyond the constants header
// Notes: power mode enumeration shared with the core
package wwdt_pkg;
  typedef enum logic [1:0] {
    PmRun,
    PmIdle,
    PmSleep
  } wwdt_pmode_t;
endpackage

// ### verilog/wwdt_sync.sv
// Purpose: two-flop synchroniser with rising edge detect
// Assumes: single clock domain on the output side
// Notes: first flop is read only by the second
`timescale 1ns/1ps
`default_nettype none
module wwdt_sync (
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  input wire logic ce,
  // Data
  input wire logic asyncIn,
  output logic rise
);
  logic meta_q;
  logic sync_q;
  logic last_q;

  // Edge taken only from the second flop
  always_ff @(posedge clk) begin
    if (!rstn) begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
      last_q <= 1'b0;
    end else if (ce) begin
      meta_q <= asyncIn;
      sync_q <= meta_q;
      last_q <= sync_q;
    end
  end

  assign rise = ce & sync_q & ~last_q;
endmodule // wwdt_sync
`default_nettype wire

// ### verilog/wwdt_top.sv
// Purpose: windowed watchdog timer with prescaler, postscaler and mode control
// Assumes: RC oscillator arrives as a slow pin clock, sampled here as a tick
// Notes: core events are one-cycle pulses on clk; flags are plain ports
`timescale 1ns/1ps
`include "wwdt_cfg.svh"
`default_nettype none
module wwdt_top (
  // Clock, reset, enable
  input wire logic clk,
  input wire logic rstn,
  input wire logic ce,
  // Oscillator
  input wire logic low_power_rc_oscillator,
  output logic rcOscEnable,
  // Configuration word fields
  input wire logic prescale_select_cfg,
  input wire logic [3:0] postscale_select_cfg,
  input wire logic window_mode_disable_cfg,
  input wire logic [1:0] watchdog_enable_cfg,
  // Software enable bit access
  input wire logic swEnableWrite,
  input wire logic swEnableData,
  output logic software_watchdog_enable,
  // Core events, one-cycle pulses
  input wire logic watchdog_clear_instruction,
  input wire logic power_save_instruction,
  input wire logic powerSaveIdle,
  input wire logic clockSwitchDone,
  input wire logic lowPowerExit,
  // Time-out flag clear by software
  input wire logic timeoutFlagClear,
  // Results
  output logic watchdog_timeout_flag,
  output logic wakeRequest,
  output logic deviceReset,
  output logic [1:0] powerMode
);
  typedef struct packed {
    logic [6:0] pre;
    logic [`WWDT_POST_W-1:0] post;
    logic swEn;
    logic flag;
    logic wake;
    logic rst;
    logic oscEn;
    wwdt_pkg::wwdt_pmode_t mode;
  } wwdt_state_t;

  wwdt_state_t s_q;
  wwdt_state_t s_d;
  logic tick;
  logic running;
  logic [6:0] preMax;
  logic [`WWDT_POST_W-1:0] postMax;
  logic [`WWDT_POST_W-1:0] postFull;
  logic preWrap;
  logic timeout;
  logic inWindow;
  logic [7:0] preFull;
  logic [`WWDT_POST_W+7:0] elapsed;
  logic [`WWDT_POST_W+7:0] period;

  // RC ticks cross into the clk domain here
  wwdt_sync uSync (
    .clk(clk),
    .rstn(rstn),
    .ce(ce),
    .asyncIn(low_power_rc_oscillator),
    .rise(tick)
  );

  // Enable decode; 01 stops in Sleep, 11 runs everywhere
  always_comb begin
    case (watchdog_enable_cfg)
      `WWDT_EN_HW: running = 1'b1;
      `WWDT_EN_SW: running = s_q.swEn;
      `WWDT_EN_ACTIVE: running = (s_q.mode != wwdt_pkg::PmSleep);
      default: running = 1'b0;
    endcase
  end

  // Ratio selection
  assign preMax = prescale_select_cfg ? `WWDT_PRE_LARGE : `WWDT_PRE_SMALL;
  assign postFull = {`WWDT_POST_W{1'b1}};
  assign postMax = postFull >> (`WWDT_POST_W - {28'h0, postselExt(postscale_select_cfg)});

  // Pass postscale code through unchanged; the concatenation widens it for the shift
  function automatic logic [3:0] postselExt(input logic [3:0] code);
    postselExt = code;
  endfunction

  assign preWrap = tick && (s_q.pre == preMax);
  assign timeout = running && preWrap && (s_q.post == postMax);

  // Elapsed count against period for the window check
  assign preFull = {1'b0, preMax} + 8'h01;
  assign elapsed = ({8'h0, s_q.post} * {{`WWDT_POST_W{1'b0}}, preFull})
    + {{(`WWDT_POST_W+1){1'b0}}, s_q.pre};
  assign period = ({8'h0, postMax} + {{(`WWDT_POST_W+7){1'b0}}, 1'b1})
    * {{`WWDT_POST_W{1'b0}}, preFull};
  // Final quarter: elapsed at or past three quarters of period
  assign inWindow = (elapsed + (period >> `WWDT_WIN_SHIFT)) >= period;

  // Next-state logic for the whole block
  always_comb begin
    s_d = s_q;
    s_d.wake = 1'b0;
    s_d.rst = 1'b0;
    s_d.oscEn = running;
    if (swEnableWrite) begin
      s_d.swEn = swEnableData;
    end
    // Power mode tracking from core events
    if (power_save_instruction) begin
      s_d.mode = powerSaveIdle ? wwdt_pkg::PmIdle : wwdt_pkg::PmSleep;
    end else if (lowPowerExit) begin
      s_d.mode = wwdt_pkg::PmRun;
    end
    // Counting, only while enabled and ticking
    if (running && tick) begin
      if (preWrap) begin
        s_d.pre = 7'h00;
        s_d.post = s_q.post + {{(`WWDT_POST_W-1){1'b0}}, 1'b1};
      end else begin
        s_d.pre = s_q.pre + 7'h01;
      end
    end
    if (timeout) begin
      s_d.pre = 7'h00;
      s_d.post = '0;
      if (s_q.mode == wwdt_pkg::PmRun) begin
        s_d.rst = 1'b1;
        s_d.flag = 1'b1;
      end else begin
        s_d.wake = 1'b1;
        s_d.mode = wwdt_pkg::PmRun;
      end
    end
    // Clear sources; clear of a disabled counter is harmless
    if (clockSwitchDone || power_save_instruction || lowPowerExit) begin
      s_d.pre = 7'h00;
      s_d.post = '0;
    end
    if (watchdog_clear_instruction && s_q.mode == wwdt_pkg::PmRun) begin
      if (!window_mode_disable_cfg && running && !inWindow) begin
        s_d.rst = 1'b1;
        s_d.flag = 1'b1;
      end else begin
        s_d.pre = 7'h00;
        s_d.post = '0;
      end
    end
    // Software clear loses to a same-cycle set
    if (timeoutFlagClear && !(s_d.flag && !s_q.flag)) begin
      s_d.flag = 1'b0;
    end
    if (timeoutFlagClear && s_d.rst) begin
      s_d.flag = 1'b1;
    end
  end

  // Registers; reset zeroes chain and software enable
  always_ff @(posedge clk) begin
    if (!rstn) begin
      s_q <= '0;
    end else if (ce) begin
      s_q <= s_d;
    end
  end

  // Outputs straight from flops
  assign rcOscEnable = s_q.oscEn;
  assign software_watchdog_enable = s_q.swEn;
  assign watchdog_timeout_flag = s_q.flag;
  assign wakeRequest = s_q.wake;
  assign deviceReset = s_q.rst;
  assign powerMode = s_q.mode;
endmodule // wwdt_top
`default_nettype wire

// ### sim/wwdt_rc_model.sv
// Purpose: RC oscillator pin model
// Assumes: HALF clocks per half period
// Notes: pin stands low while not requested
`timescale 1ns/1ps
`default_nettype none
module wwdt_rc_model #(parameter int HALF = 5) (
  // Clock and request
  input wire logic clk,
  input wire logic rcOscEnable,
  // Pin
  output logic low_power_rc_oscillator
);
  int cnt = 0;
  // Pin toggles only while requested
  always @(posedge clk) begin
    cnt <= (cnt == HALF - 1) ? 0 : cnt + 1;
    if (!rcOscEnable) low_power_rc_oscillator <= 1'b0;
    else if (cnt == HALF - 1) low_power_rc_oscillator <= !low_power_rc_oscillator;
  end
  initial low_power_rc_oscillator = 1'b0;
endmodule // wwdt_rc_model
`default_nettype wire

// ### sim/wwdt_sva.sv
// Purpose: port checks of the watchdog
// Assumes: ce held high
// Notes: bound onto wwdt_top
`timescale 1ns/1ps
`default_nettype none
module wwdt_sva (
  // Clock and inputs
  input wire logic clk,
  input wire logic rstn,
  input wire logic timeoutFlagClear,
  input wire logic [1:0] watchdog_enable_cfg,
  // Results
  input wire logic rcOscEnable,
  input wire logic software_watchdog_enable,
  input wire logic watchdog_timeout_flag,
  input wire logic wakeRequest,
  input wire logic deviceReset,
  input wire logic [1:0] powerMode
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  // Pulses and sticky flag, then enable follows the mode, with slack for registered outputs
  property p_pls; deviceReset |-> watchdog_timeout_flag ##1 !deviceReset; endproperty
  a_pls: assert property (p_pls) else $error("reset pulse");
  property p_flg; watchdog_timeout_flag && !timeoutFlagClear |=> watchdog_timeout_flag; endproperty
  a_flg: assert property (p_flg) else $error("flag lost");
  property p_wk; wakeRequest |-> !deviceReset ##1 !wakeRequest; endproperty
  a_wk: assert property (p_wk) else $error("wake pulse");
  property p_off; (watchdog_enable_cfg == 2'h0) [*3] |-> !rcOscEnable; endproperty
  a_off: assert property (p_off) else $error("runs when off");
  property p_dis; deviceReset |-> $past(rcOscEnable); endproperty
  a_dis: assert property (p_dis) else $error("reset when off");
  property p_hw; (watchdog_enable_cfg == 2'h3) [*3] |-> rcOscEnable; endproperty
  a_hw: assert property (p_hw) else $error("always on");
  property p_act; (watchdog_enable_cfg == 2'h1 && powerMode == 2'h2) [*3] |-> !rcOscEnable;
  endproperty
  a_act: assert property (p_act) else $error("runs in sleep");
  property p_sw; (watchdog_enable_cfg == 2'h2 && software_watchdog_enable) [*3] |-> rcOscEnable;
  endproperty
  a_sw: assert property (p_sw) else $error("soft enable");
endmodule // wwdt_sva
`default_nettype wire

// ### sim/wwdt_bench.sv
// Purpose: self-checking bench of the watchdog
// Assumes: RC model gives a tick every ten clocks
// Notes: events are one-cycle pulses
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, s) begin n_checks++; if ((s) !== (e)) begin num_errors++; \
  $display("[FAIL] %s exp %0h got %0h", n, e, s); end end
module wwdt_bench;
  logic clk = 1'b0, rstn = 1'b0, prescale_select_cfg = 1'b0, window_mode_disable_cfg = 1'b1;
  logic ce = 1'b1, swEnableData = 1'b1, powerSaveIdle = 1'b0;
  logic [3:0] postscale_select_cfg = 4'h0;
  logic [1:0] watchdog_enable_cfg = 2'h0;
  logic [5:0] ev = 6'h0;
  int n_checks = 0, num_errors = 0, cyc = 0;
  wire low_power_rc_oscillator, rcOscEnable, software_watchdog_enable, watchdog_timeout_flag;
  wire wakeRequest, deviceReset, watchdog_clear_instruction, power_save_instruction;
  wire clockSwitchDone, lowPowerExit, timeoutFlagClear, swEnableWrite;
  wire [1:0] powerMode;
  assign {swEnableWrite, timeoutFlagClear, lowPowerExit, clockSwitchDone, power_save_instruction,
    watchdog_clear_instruction} = ev;
  wwdt_top u_dut (.*);
  wwdt_rc_model u_rc (.*);
  always #4 clk = ~clk;
  // Hang guard, far above the expected run
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      num_errors++;
      finish_test;
    end
  end
  task automatic pulse(input int i);
    @(posedge clk) ev[i] <= 1'b1;
    @(posedge clk) ev <= 6'h0;
  endtask
  // Event placed just after a tick so no rise is half synchronised
  task automatic start(input int i);
    while (low_power_rc_oscillator !== 1'b0) @(posedge clk);
    while (low_power_rc_oscillator !== 1'b1) @(posedge clk);
    repeat (3) @(posedge clk);
    pulse(i);
  endtask
  task automatic ticks(output int n);
    logic p;
    n = 0;
    p = low_power_rc_oscillator;
    repeat (4000) begin
      @(posedge clk);
      if (deviceReset === 1'b1 || wakeRequest === 1'b1) break;
      n += int'(low_power_rc_oscillator && !p);
      p = low_power_rc_oscillator;
    end
  endtask
  task automatic tmo(input logic p, input logic [3:0] c, input int e);
    int n;
    prescale_select_cfg <= p;
    postscale_select_cfg <= c;
    start(2);
    ticks(n);
    `CHK("ticks", e, n)
    `CHK("flag", 2'h3, {deviceReset, watchdog_timeout_flag})
    pulse(4);
    $display("end tmo %0d", e);
  endtask
  task automatic win;
    int n;
    window_mode_disable_cfg <= 1'b0;
    start(2);
    pulse(0);
    @(posedge clk);
    `CHK("early", 1'b1, deviceReset)
    start(2);
    // About 200 of 256 ticks: inside the final quarter, short of time-out
    repeat (2000) @(posedge clk);
    pulse(0);
    @(posedge clk);
    `CHK("late", 1'b0, deviceReset)
    ticks(n);
    `CHK("restart", 256, n)
    window_mode_disable_cfg <= 1'b1;
    pulse(4);
    $display("end win");
  endtask
  task automatic slp;
    int n;
    start(1);
    ticks(n);
    `CHK("sleep", 256, n)
    `CHK("wake", 2'h2, {wakeRequest, deviceReset})
    pulse(3);
    watchdog_enable_cfg <= 2'h1;
    start(1);
    ticks(n);
    `CHK("stop", 0, n)
    pulse(3);
    @(posedge clk);
    `CHK("run", 2'h0, powerMode)
    $display("end slp");
  endtask
  task finish_test;
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    repeat (3) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    `CHK("swen", 1'b0, software_watchdog_enable)
    window_mode_disable_cfg <= 1'b0;
    pulse(0);
    @(posedge clk);
    `CHK("off", 2'h0, {deviceReset, rcOscEnable})
    window_mode_disable_cfg <= 1'b1;
    watchdog_enable_cfg <= 2'h2;
    pulse(5);
    tmo(1'b0, 4'h0, 32);
    watchdog_enable_cfg <= 2'h3;
    tmo(1'b1, 4'h0, 128);
    tmo(1'b1, 4'h1, 256);
    win;
    slp;
    finish_test;
  end
endmodule // wwdt_bench
bind wwdt_top wwdt_sva u_sva (.*);
`default_nettype wire
